// ---- hw/ieb_pkg.sv ----
// Constants and operation codes for the integer execute and branch unit
// Overview of operation
// - Sign-extend arithmetic immediates, zero-extend logical ones
// - Scaled add shifts one operand by 1..4
// - Upper-immediate add: sign-extend, shift 16, add
// - PC add scaled 19-bit immediate times four
// - PC add immediate shifted up sixteen
// - Aligned PC add clears low sixteen bits
// - Unsigned-named adds never flag overflow
// - Reverse bits inside each byte
// - Align extracts byte-positioned word from pair
// - Align equals rt shl 8bp or rs shr
// - Low product common, high product signedness-dependent
// - High multiply writes upper product word only
// - Divide writes quotient only, per signedness
// - Remainder writes remainder only, per signedness
// - Low multiply product reused by following high
// - Delayed transfer: next instruction always executes
// - Absolute jump: index shl 2, PC top four
// - Delayed branch: slot address plus offset times four
// - Conditional compact: forbidden slot; unconditional: none
// - Slot holding returns, waits or transfers: reserved
// - Far jump/call 26-bit word offset, call links
// - Far target is PC plus four plus offset
// - Register jump adds unscaled 16-bit offset
// - Zero-compare compact branches use 21-bit offset
// - Reg-reg compact compares use 16-bit offset
// - Overflow branches test signed word add overflow
package ieb_pkg;
	localparam int XLEN        = 32;
	localparam int IMM16_W     = 16;
	localparam int IMM19_W     = 19;
	localparam int OFF21_W     = 21;
	localparam int OFF26_W     = 26;
	localparam int UPPER_SHIFT = 16;
	localparam int WORD_SHIFT  = 2;
	localparam int PC_TOP_W    = 4;
	localparam int BYTE_W      = 8;
	localparam logic [XLEN-1:0] PC_STEP = 32'h0000_0004;
	localparam logic [XLEN-1:0] LOW16_CLR = 32'hffff_0000;

	typedef enum logic [5:0] {
		IEB_OP_ADD_SIGNED   = 6'h00, // traps on overflow
		IEB_OP_ADD_NOTRAP   = 6'h01,
		IEB_OP_SUB_SIGNED   = 6'h02,
		IEB_OP_SUB_NOTRAP   = 6'h03,
		IEB_OP_AND          = 6'h04,
		IEB_OP_OR           = 6'h05,
		IEB_OP_XOR          = 6'h06,
		IEB_OP_NOR          = 6'h07,
		IEB_OP_SLT          = 6'h08,
		IEB_OP_SLTU         = 6'h09,
		IEB_OP_SCALED_ADD   = 6'h0a,
		IEB_OP_ADD_UPPER    = 6'h0b,
		IEB_OP_PC_SCALED    = 6'h0c,
		IEB_OP_PC_UPPER     = 6'h0d,
		IEB_OP_PC_UPPER_AL  = 6'h0e,
		IEB_OP_BIT_REVERSE  = 6'h0f,
		IEB_OP_ALIGN        = 6'h10,
		IEB_OP_PROD_LO_S    = 6'h11,
		IEB_OP_PROD_LO_U    = 6'h12,
		IEB_OP_PROD_HI_S    = 6'h13,
		IEB_OP_PROD_HI_U    = 6'h14,
		IEB_OP_QUOT_S       = 6'h15,
		IEB_OP_QUOT_U       = 6'h16,
		IEB_OP_REM_S        = 6'h17,
		IEB_OP_REM_U        = 6'h18,
		IEB_OP_JUMP_ABS     = 6'h19, // delayed
		IEB_OP_JUMP_REG     = 6'h1a, // delayed
		IEB_OP_BR_DELAYED   = 6'h1b, // delayed conditional
		IEB_OP_FAR_JUMP     = 6'h1c,
		IEB_OP_FAR_CALL     = 6'h1d,
		IEB_OP_REGOFF_JUMP  = 6'h1e,
		IEB_OP_REGOFF_CALL  = 6'h1f,
		IEB_OP_BR_ZERO_C    = 6'h20,
		IEB_OP_BR_NZERO_C   = 6'h21,
		IEB_OP_BR_EQ_C      = 6'h22,
		IEB_OP_BR_NE_C      = 6'h23,
		IEB_OP_BR_GE_C      = 6'h24,
		IEB_OP_BR_LT_C      = 6'h25,
		IEB_OP_BR_GEU_C     = 6'h26,
		IEB_OP_BR_LTU_C     = 6'h27,
		IEB_OP_BR_OV_C      = 6'h28,
		IEB_OP_BR_NOV_C     = 6'h29,
		IEB_OP_SLOT_BANNED  = 6'h2a, // returns, wait, pause
		IEB_OP_NOP          = 6'h3f
	} ieb_op_e;

	typedef enum logic [2:0] {
		IEB_DCOND_EQ = 3'h0,
		IEB_DCOND_NE = 3'h1,
		IEB_DCOND_LEZ = 3'h2,
		IEB_DCOND_GTZ = 3'h3,
		IEB_DCOND_LTZ = 3'h4,
		IEB_DCOND_GEZ = 3'h5
	} ieb_dcond_e;

	typedef enum logic [2:0] {
		IEB_SLOT_NONE      = 3'b001,
		IEB_SLOT_DELAY     = 3'b010,
		IEB_SLOT_FORBIDDEN = 3'b100
	} ieb_slot_e;
endpackage

// ---- hw/ieb_unit.sv ----
// Execute-stage datapath for integer, multiply/divide and branch ops
`timescale 1ns/10ps
module ieb_unit #(
	parameter int WIDTH = 32
) (
	// Clock and reset
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	// Issue from decode
	input  wire logic                   issue_valid_i,
	input  wire ieb_pkg::ieb_op_e       issue_op_i,
	input  wire logic [WIDTH-1:0]       pc_i,
	input  wire logic [WIDTH-1:0]       src_a_i,
	input  wire logic [WIDTH-1:0]       src_b_i,
	input  wire logic [25:0]            imm_i,
	input  wire logic                   imm_logical_i,
	input  wire logic [4:0]             dest_i,
	input  wire logic [1:0]             scale_i,
	input  wire logic [1:0]             byte_pos_i,
	input  wire ieb_pkg::ieb_dcond_e    dcond_i,
	// Result to register file
	output logic                        wr_en_o,
	output logic [4:0]                  wr_dest_o,
	output logic [WIDTH-1:0]            wr_data_o,
	// Redirect to fetch
	output logic                        redirect_o,
	output logic [WIDTH-1:0]            target_o,
	output logic                        slot_delay_o,
	output logic                        slot_forbidden_o,
	// Exceptions
	output logic                        overflow_exc_o,
	output logic                        reserved_exc_o
);
	import ieb_pkg::*;

	// Encodings and link arithmetic assume a 32-bit word
	if (WIDTH != XLEN) begin
		$error("ieb_unit: WIDTH must equal 32");
	end

	// Calls always link into the last general register
	localparam logic [4:0] LINK_REG = 5'h1f;

	// Sign extension of an immediate slice to register width
	// Bits above the slice repeat its top bit
	function automatic logic [WIDTH-1:0] sext(input logic [25:0] v,
			input int w);
		logic [WIDTH-1:0] r;
		r = '0;
		for (int i = 0; i < WIDTH; i++)
			r[i] = (i < w) ? v[i] : v[w-1];
		return r;
	endfunction

	// Signed add overflow detect, shared by traps and branches
	function automatic logic add_ovf(input logic [WIDTH-1:0] a,
			input logic [WIDTH-1:0] b, input logic [WIDTH-1:0] s);
		return (a[WIDTH-1] == b[WIDTH-1]) && (s[WIDTH-1] != a[WIDTH-1]);
	endfunction

	// Slot state: what kind of slot the next instruction lands in
	ieb_slot_e slot;
	ieb_slot_e next_slot;

	// Multiplier reuse cache
	logic               prod_keep;
	logic               prod_keep_signed;
	logic [WIDTH-1:0]   prod_keep_a;
	logic [WIDTH-1:0]   prod_keep_b;
	logic [2*WIDTH-1:0] prod_keep_val;

	// Immediate forms
	wire [WIDTH-1:0] imm16_s = sext(imm_i, IMM16_W);
	wire [WIDTH-1:0] imm16_z = {{(WIDTH-IMM16_W){1'b0}},
		imm_i[IMM16_W-1:0]};
	wire [WIDTH-1:0] imm_alu = imm_logical_i ? imm16_z : imm16_s;
	wire [WIDTH-1:0] imm_upper = imm16_s << UPPER_SHIFT;
	wire [WIDTH-1:0] imm19_sc = sext(imm_i, IMM19_W) << WORD_SHIFT;
	wire [WIDTH-1:0] off16_sc = imm16_s << WORD_SHIFT;
	wire [WIDTH-1:0] off21_sc = sext(imm_i, OFF21_W) << WORD_SHIFT;
	wire [WIDTH-1:0] off26_sc = sext(imm_i, OFF26_W) << WORD_SHIFT;

	// Core arithmetic; b operand is always src_b_i, imm_alu feeds only AND, OR and XOR
	wire [WIDTH-1:0] add_sum = src_a_i + src_b_i;
	wire [WIDTH-1:0] sub_dif = src_a_i - src_b_i;
	wire             add_of  = add_ovf(src_a_i, src_b_i, add_sum);
	wire             sub_of  = add_ovf(src_a_i, ~src_b_i, sub_dif);
	wire             lt_s    = $signed(src_a_i) < $signed(src_b_i);
	wire             lt_u    = src_a_i < src_b_i;
	wire             eq      = src_a_i == src_b_i;

	// Scaled add: shift of 1 to 4 positions
	wire [2:0]       scale_amt = {1'b0, scale_i} + 3'h1;
	wire [WIDTH-1:0] scaled_sum = (src_a_i << scale_amt) + src_b_i;

	// PC-relative sums
	wire [WIDTH-1:0] pc_scaled = pc_i + imm19_sc;
	wire [WIDTH-1:0] pc_upper  = pc_i + imm_upper;
	wire [WIDTH-1:0] pc_upper_al = pc_upper & LOW16_CLR;

	// Bit reverse inside each byte, byte order kept
	logic [WIDTH-1:0] bit_rev;
	always_comb begin
		for (int i = 0; i < WIDTH; i++)
			bit_rev[i] = src_a_i[(i/BYTE_W)*BYTE_W + (BYTE_W-1) - (i%BYTE_W)];
	end

	// Align; position zero must not shift a by a full word
	wire [5:0] bp_bits = {1'b0, byte_pos_i, 3'h0};
	wire [5:0] rs_sh   = 6'(WIDTH) - bp_bits;
	wire [WIDTH-1:0] aligned = (byte_pos_i == 2'h0) ? src_b_i :
		((src_b_i << bp_bits) | (src_a_i >> rs_sh));

	// Multiply with reuse of the kept full product
	wire             is_mul_s = (issue_op_i == IEB_OP_PROD_LO_S) ||
		(issue_op_i == IEB_OP_PROD_HI_S);
	wire [2*WIDTH-1:0] prod_s = $signed(src_a_i) * $signed(src_b_i);
	wire [2*WIDTH-1:0] prod_u = src_a_i * src_b_i;
	wire             is_mul_hi = (issue_op_i == IEB_OP_PROD_HI_S) ||
		(issue_op_i == IEB_OP_PROD_HI_U);
	// Operands are compared too, so a rewritten register never hits
	wire             reuse_hit = is_mul_hi && prod_keep &&
		(prod_keep_signed == is_mul_s) &&
		(prod_keep_a == src_a_i) && (prod_keep_b == src_b_i);
	wire [2*WIDTH-1:0] prod = reuse_hit ? prod_keep_val :
		(is_mul_s ? prod_s : prod_u);

	// Divide; zero divisor gives zero and most-negative/-1 wraps
	// Single-cycle divide keeps issue simple at a timing cost
	wire             div_zero = src_b_i == '0;
	wire             div_wrap = (src_a_i == {1'b1, {(WIDTH-1){1'b0}}}) &&
		(src_b_i == '1);
	wire [WIDTH-1:0] quot_s = (div_zero || div_wrap) ?
		(div_wrap ? src_a_i : '0) : WIDTH'($signed(src_a_i) / $signed(src_b_i));
	wire [WIDTH-1:0] rem_s = (div_zero || div_wrap) ? '0 :
		WIDTH'($signed(src_a_i) % $signed(src_b_i));
	wire [WIDTH-1:0] quot_u = div_zero ? '0 : src_a_i / src_b_i;
	wire [WIDTH-1:0] rem_u  = div_zero ? '0 : src_a_i % src_b_i;

	// Branch targets
	// Delay-slot address is the base of links and most targets
	wire [WIDTH-1:0] pc_next  = pc_i + PC_STEP;
	wire [WIDTH-1:0] tgt_abs  = {pc_next[WIDTH-1 -: PC_TOP_W],
		imm_i, 2'b00};
	wire [WIDTH-1:0] tgt_dly  = pc_next + off16_sc;
	wire [WIDTH-1:0] tgt_far  = pc_next + off26_sc;
	wire [WIDTH-1:0] tgt_reg  = src_a_i + imm16_s;
	wire [WIDTH-1:0] tgt_z21  = pc_next + off21_sc;
	wire [WIDTH-1:0] tgt_c16  = pc_next + off16_sc;
	wire             a_zero   = src_a_i == '0;
	wire             a_neg    = src_a_i[WIDTH-1];

	// Delayed branch condition
	// Codes outside the six conditions never take the branch
	logic dly_take;
	always_comb begin
		unique case (dcond_i)
			IEB_DCOND_EQ:  dly_take = eq;
			IEB_DCOND_NE:  dly_take = !eq;
			IEB_DCOND_LEZ: dly_take = a_neg || a_zero;
			IEB_DCOND_GTZ: dly_take = !a_neg && !a_zero;
			IEB_DCOND_LTZ: dly_take = a_neg;
			IEB_DCOND_GEZ: dly_take = !a_neg;
			default:       dly_take = 1'b0;
		endcase
	end

	// Instruction in a delay or forbidden slot that may not sit there
	wire is_cti = (issue_op_i >= IEB_OP_JUMP_ABS) &&
		(issue_op_i <= IEB_OP_BR_NOV_C);
	wire slot_bad = (slot != IEB_SLOT_NONE) &&
		(is_cti || issue_op_i == IEB_OP_SLOT_BANNED);

	// Result and control selection
	logic             n_wr;
	logic [4:0]       n_dest;
	logic [WIDTH-1:0] n_data;
	logic             n_redir;
	logic [WIDTH-1:0] n_tgt;
	logic             n_ovf;
	always_comb begin
		n_wr = 1'b1;
		n_dest = dest_i;
		n_data = '0;
		n_redir = 1'b0;
		n_tgt = '0;
		n_ovf = 1'b0;
		next_slot = IEB_SLOT_NONE;
		case (issue_op_i)
			IEB_OP_ADD_SIGNED: begin
				n_data = add_sum;
				n_ovf = add_of;
			end
			IEB_OP_ADD_NOTRAP:  n_data = add_sum;
			IEB_OP_SUB_SIGNED: begin
				n_data = sub_dif;
				n_ovf = sub_of;
			end
			IEB_OP_SUB_NOTRAP:  n_data = sub_dif;
			IEB_OP_AND:         n_data = src_a_i & imm_alu;
			IEB_OP_OR:          n_data = src_a_i | imm_alu;
			IEB_OP_XOR:         n_data = src_a_i ^ imm_alu;
			IEB_OP_NOR:         n_data = ~(src_a_i | src_b_i);
			IEB_OP_SLT:         n_data = {{(WIDTH-1){1'b0}}, lt_s};
			IEB_OP_SLTU:        n_data = {{(WIDTH-1){1'b0}}, lt_u};
			IEB_OP_SCALED_ADD:  n_data = scaled_sum;
			IEB_OP_ADD_UPPER:   n_data = src_a_i + imm_upper;
			IEB_OP_PC_SCALED:   n_data = pc_scaled;
			IEB_OP_PC_UPPER:    n_data = pc_upper;
			IEB_OP_PC_UPPER_AL: n_data = pc_upper_al;
			IEB_OP_BIT_REVERSE: n_data = bit_rev;
			IEB_OP_ALIGN:       n_data = aligned;
			IEB_OP_PROD_LO_S,
			IEB_OP_PROD_LO_U:   n_data = prod[WIDTH-1:0];
			IEB_OP_PROD_HI_S,
			IEB_OP_PROD_HI_U:   n_data = prod[2*WIDTH-1:WIDTH];
			IEB_OP_QUOT_S:      n_data = quot_s;
			IEB_OP_QUOT_U:      n_data = quot_u;
			IEB_OP_REM_S:       n_data = rem_s;
			IEB_OP_REM_U:       n_data = rem_u;
			IEB_OP_JUMP_ABS: begin
				n_wr = 1'b0;
				n_redir = 1'b1;
				n_tgt = tgt_abs;
				next_slot = IEB_SLOT_DELAY;
			end
			IEB_OP_JUMP_REG: begin
				n_wr = 1'b0;
				n_redir = 1'b1;
				n_tgt = src_a_i;
				next_slot = IEB_SLOT_DELAY;
			end
			IEB_OP_BR_DELAYED: begin
				n_wr = 1'b0;
				n_redir = dly_take;
				n_tgt = tgt_dly;
				next_slot = IEB_SLOT_DELAY;
			end
			IEB_OP_FAR_JUMP, IEB_OP_FAR_CALL: begin
				n_wr = issue_op_i == IEB_OP_FAR_CALL;
				n_dest = LINK_REG;
				n_data = pc_next;
				n_redir = 1'b1;
				n_tgt = tgt_far;
			end
			IEB_OP_REGOFF_JUMP, IEB_OP_REGOFF_CALL: begin
				n_wr = issue_op_i == IEB_OP_REGOFF_CALL;
				n_dest = LINK_REG;
				n_data = pc_next;
				n_redir = 1'b1;
				n_tgt = tgt_reg;
			end
			IEB_OP_BR_ZERO_C, IEB_OP_BR_NZERO_C: begin
				n_wr = 1'b0;
				n_redir = a_zero == (issue_op_i == IEB_OP_BR_ZERO_C);
				n_tgt = tgt_z21;
				next_slot = IEB_SLOT_FORBIDDEN;
			end
			IEB_OP_BR_EQ_C, IEB_OP_BR_NE_C, IEB_OP_BR_GE_C,
			IEB_OP_BR_LT_C, IEB_OP_BR_GEU_C, IEB_OP_BR_LTU_C,
			IEB_OP_BR_OV_C, IEB_OP_BR_NOV_C: begin
				n_wr = 1'b0;
				n_tgt = tgt_c16;
				next_slot = IEB_SLOT_FORBIDDEN;
				unique case (issue_op_i)
					IEB_OP_BR_EQ_C:  n_redir = eq;
					IEB_OP_BR_NE_C:  n_redir = !eq;
					IEB_OP_BR_GE_C:  n_redir = !lt_s;
					IEB_OP_BR_LT_C:  n_redir = lt_s;
					IEB_OP_BR_GEU_C: n_redir = !lt_u;
					IEB_OP_BR_LTU_C: n_redir = lt_u;
					IEB_OP_BR_OV_C:  n_redir = add_of;
					default:         n_redir = !add_of;
				endcase
			end
			default:            n_wr = 1'b0;
		endcase
		// A banned slot occupant commits nothing
		if (!issue_valid_i || slot_bad) begin
			n_wr = 1'b0;
			n_redir = 1'b0;
			n_ovf = 1'b0;
			next_slot = IEB_SLOT_NONE;
		end
		// A trapping overflow must leave the destination untouched
		if (n_ovf)
			n_wr = 1'b0;
	end

	// Output registers; one register written per op
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_en_o <= 1'b0;
			wr_dest_o <= '0;
			wr_data_o <= '0;
			redirect_o <= 1'b0;
			target_o <= '0;
			overflow_exc_o <= 1'b0;
			reserved_exc_o <= 1'b0;
		end else begin
			wr_en_o <= n_wr;
			wr_dest_o <= n_dest;
			wr_data_o <= n_data;
			redirect_o <= n_redir;
			target_o <= n_tgt;
			overflow_exc_o <= n_ovf;
			reserved_exc_o <= issue_valid_i && slot_bad;
		end
	end

	// Slot tracker advances only on issued instructions
	always_ff @(posedge clk_i) begin
		if (rst_i)
			slot <= IEB_SLOT_NONE;
		else if (issue_valid_i)
			slot <= next_slot;
	end

	// Slot flags decode the one-hot tracker directly
	assign slot_delay_o = slot == IEB_SLOT_DELAY;
	assign slot_forbidden_o = slot == IEB_SLOT_FORBIDDEN;

	// Keep the low-part product; any other issue drops it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prod_keep <= 1'b0;
			prod_keep_signed <= 1'b0;
			prod_keep_a <= '0;
			prod_keep_b <= '0;
			prod_keep_val <= '0;
		end else if (issue_valid_i) begin
			prod_keep <= !slot_bad && ((issue_op_i == IEB_OP_PROD_LO_S) ||
				(issue_op_i == IEB_OP_PROD_LO_U));
			prod_keep_signed <= is_mul_s;
			prod_keep_a <= src_a_i;
			prod_keep_b <= src_b_i;
			prod_keep_val <= prod;
		end
	end
endmodule

// ---- testbench/ieb_unit_monitor.sv ----
// Port checker for the integer execute and branch unit
`timescale 1ns/10ps
module ieb_unit_monitor
	import ieb_pkg::*;
#(
	parameter int WIDTH = 32
) (
	// Clock, reset and issue
	input wire logic             clk_i,
	input wire logic             rst_i,
	input wire logic             issue_valid_i,
	input wire ieb_pkg::ieb_op_e issue_op_i,
	input wire logic [WIDTH-1:0] pc_i,
	input wire logic [WIDTH-1:0] src_a_i,
	input wire logic [WIDTH-1:0] src_b_i,
	input wire logic [25:0]      imm_i,
	input wire logic [1:0]       byte_pos_i,
	// Results
	input wire logic             wr_en_o,
	input wire logic [4:0]       wr_dest_o,
	input wire logic [WIDTH-1:0] wr_data_o,
	input wire logic             redirect_o,
	input wire logic [WIDTH-1:0] target_o,
	input wire logic             slot_delay_o,
	input wire logic             slot_forbidden_o,
	input wire logic             overflow_exc_o,
	input wire logic             reserved_exc_o
);
	// Expected values formed from the issuing inputs
	wire logic idle = !slot_delay_o && !slot_forbidden_o;
	wire logic go = issue_valid_i && idle;
	wire logic control_transfer_instr = issue_op_i >= IEB_OP_JUMP_ABS
		&& issue_op_i <= IEB_OP_SLOT_BANNED;
	wire logic [WIDTH-1:0] far_off = {{4{imm_i[25]}}, imm_i, 2'b00};
	wire logic [WIDTH-1:0] al_exp = (pc_i + {imm_i[15:0], 16'h0}) & LOW16_CLR;
	wire logic [WIDTH-1:0] algn = (byte_pos_i == 2'h0) ? src_b_i
		: (src_b_i << (8 * byte_pos_i)) | (src_a_i >> (32 - 8 * byte_pos_i));

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_far_link:
	assert property (go && issue_op_i == IEB_OP_FAR_CALL |=> wr_en_o
		&& wr_dest_o == 5'h1f && wr_data_o == $past(pc_i) + 32'h4)
		else $error("far call link wrong");
	a_far_target:
	assert property (go && (issue_op_i inside {IEB_OP_FAR_JUMP,
		IEB_OP_FAR_CALL}) |=> redirect_o && idle
		&& target_o == $past(pc_i) + 32'h4 + $past(far_off))
		else $error("far target wrong");
	a_delay_set:
	assert property (go && issue_op_i >= IEB_OP_JUMP_ABS
		&& issue_op_i <= IEB_OP_BR_DELAYED |=> slot_delay_o
		&& !slot_forbidden_o) else $error("delay slot not opened");
	a_forbid_set:
	assert property (go && issue_op_i >= IEB_OP_BR_ZERO_C
		&& issue_op_i <= IEB_OP_BR_NOV_C |=> slot_forbidden_o
		&& !slot_delay_o) else $error("forbidden slot not opened");
	a_slot_refuse:
	assert property (issue_valid_i && !idle && control_transfer_instr |=> reserved_exc_o
		&& !wr_en_o && !redirect_o && idle)
		else $error("slot transfer not refused");
	a_notrap_add:
	assert property (go && (issue_op_i inside {IEB_OP_ADD_NOTRAP,
		IEB_OP_PC_SCALED}) |=> wr_en_o && !overflow_exc_o)
		else $error("unsigned add flagged");
	a_pc_aligned:
	assert property (go && issue_op_i == IEB_OP_PC_UPPER_AL |=> wr_en_o
		&& wr_data_o == $past(al_exp)) else $error("aligned pc add wrong");
	a_align_word:
	assert property (go && issue_op_i == IEB_OP_ALIGN |=>
		wr_data_o == $past(algn)) else $error("align result wrong");
	a_one_write:
	assert property (wr_en_o |-> $past(issue_valid_i) && !reserved_exc_o
		&& !overflow_exc_o) else $error("write without single issue");

	// Main scenarios seen
	c_call: cover property (wr_en_o && redirect_o);
	c_refuse: cover property (reserved_exc_o);
	c_ovf: cover property (overflow_exc_o);
endmodule

bind ieb_unit ieb_unit_monitor #(.WIDTH(WIDTH)) mon_u (
	.clk_i(clk_i), .rst_i(rst_i), .issue_valid_i(issue_valid_i),
	.issue_op_i(issue_op_i), .pc_i(pc_i), .src_a_i(src_a_i),
	.src_b_i(src_b_i), .imm_i(imm_i), .byte_pos_i(byte_pos_i),
	.wr_en_o(wr_en_o), .wr_dest_o(wr_dest_o), .wr_data_o(wr_data_o),
	.redirect_o(redirect_o), .target_o(target_o),
	.slot_delay_o(slot_delay_o), .slot_forbidden_o(slot_forbidden_o),
	.overflow_exc_o(overflow_exc_o), .reserved_exc_o(reserved_exc_o)
);

// ---- testbench/ieb_core_model.sv ----
// Register file and fetch sink beside the unit
`timescale 1ns/10ps
module ieb_core_model (
	// Clock
	input  wire logic        clk_i,
	// From the unit
	input  wire logic        wr_en_i,
	input  wire logic [4:0]  wr_dest_i,
	input  wire logic [31:0] wr_data_i,
	input  wire logic        redirect_i,
	input  wire logic [31:0] target_i,
	// Address that fetch moves to, and the stored link
	output logic [31:0]      fetch_pc_o,
	output logic [31:0]      link_o
);
	logic [31:0] regs [32];
	// Calls leave their return address in the last register
	assign link_o = regs[5'h1f];
	// Register zero is hardwired, so writes there are dropped
	always_ff @(posedge clk_i) begin
		if (wr_en_i && wr_dest_i != 5'h0) begin
			regs[wr_dest_i] <= wr_data_i;
		end
		if (redirect_i) begin
			fetch_pc_o <= target_i;
		end
	end
endmodule

// ---- testbench/ieb_unit_bench.sv ----
// Self-checking bench for the integer execute and branch unit
`timescale 1ns/10ps
module ieb_unit_bench;
	import ieb_pkg::*;
	logic        clk_i = 0, rst_i = 1, issue_valid_i = 0, imm_logical_i = 0;
	ieb_op_e     issue_op_i = IEB_OP_NOP;
	ieb_dcond_e  dcond_i = IEB_DCOND_EQ;
	logic [31:0] pc_i = 0, src_a_i = 0, src_b_i = 0, fetch_pc, link_reg;
	logic [25:0] imm_i = 0;
	logic [4:0]  dest_i = 5'h3, wr_dest_o;
	logic [1:0]  scale_i = 0, byte_pos_i = 0;
	logic        wr_en_o, redirect_o, slot_delay_o, slot_forbidden_o;
	logic        overflow_exc_o, reserved_exc_o;
	logic [31:0] wr_data_o, target_o;
	int          err_count = 0, checked = 0;

	always #5 clk_i = ~clk_i;

	ieb_unit #(.WIDTH(32)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
		.issue_valid_i(issue_valid_i), .issue_op_i(issue_op_i), .pc_i(pc_i),
		.src_a_i(src_a_i), .src_b_i(src_b_i), .imm_i(imm_i),
		.imm_logical_i(imm_logical_i), .dest_i(dest_i), .scale_i(scale_i),
		.byte_pos_i(byte_pos_i), .dcond_i(dcond_i), .wr_en_o(wr_en_o),
		.wr_dest_o(wr_dest_o), .wr_data_o(wr_data_o),
		.redirect_o(redirect_o), .target_o(target_o),
		.slot_delay_o(slot_delay_o), .slot_forbidden_o(slot_forbidden_o),
		.overflow_exc_o(overflow_exc_o), .reserved_exc_o(reserved_exc_o));
	ieb_core_model core_u (.clk_i(clk_i), .wr_en_i(wr_en_o),
		.wr_dest_i(wr_dest_o), .wr_data_i(wr_data_o),
		.redirect_i(redirect_o), .target_i(target_o), .fetch_pc_o(fetch_pc),
		.link_o(link_reg));

	task automatic chk(input logic [31:0] g, e, input string what);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, g, e);
		end
	endtask
	// Inputs change 1 ns after the edge so sampling is never racy
	task automatic put(input ieb_op_e o, input logic [31:0] p, a, b,
		input logic [25:0] m);
		@(posedge clk_i);
		#1;
		issue_op_i = o;
		pc_i = p;
		src_a_i = a;
		src_b_i = b;
		imm_i = m;
		issue_valid_i = 1'b1;
	endtask
	// Drop valid; the last result is then settled on the outputs
	task automatic fin;
		@(posedge clk_i);
		#1;
		issue_valid_i = 1'b0;
	endtask
	task automatic run(input ieb_op_e o, input logic [31:0] p, a, b,
		input logic [25:0] m);
		put(o, p, a, b, m);
		fin;
	endtask

	task automatic t_alu;
		logic [31:0] al [4];
		ieb_op_e     lops [6];
		logic [31:0] lex [6];
		al = '{32'h11223344, 32'h223344aa, 32'h3344aabb, 32'h44aabbcc};
		imm_logical_i = 1;
		run(IEB_OP_AND, 0, '1, '1, 26'h8000);
		chk(wr_data_o, 32'h8000, "and zero ext");
		imm_logical_i = 0;
		run(IEB_OP_AND, 0, '1, '1, 26'h8000);
		chk(wr_data_o, 32'hffff8000, "and sign ext");
		for (int s = 0; s < 4; s++) begin
			scale_i = s[1:0];
			run(IEB_OP_SCALED_ADD, 0, 3, 16, 0);
			chk(wr_data_o, (32'h3 << (s + 1)) + 32'h10, "scaled");
		end
		for (int p = 0; p < 4; p++) begin
			byte_pos_i = p[1:0];
			run(IEB_OP_ALIGN, 0, 32'haabbccdd, 32'h11223344, 0);
			chk(wr_data_o, al[p], "align");
		end
		run(IEB_OP_ADD_UPPER, 0, 32'h10000, 0, 26'h8000);
		chk(wr_data_o, 32'h80010000, "upper add");
		run(IEB_OP_PC_SCALED, 32'h1000, 0, 0, 26'h7ffff);
		chk(wr_data_o, 32'hffc, "pc scaled");
		run(IEB_OP_PC_UPPER, 32'h12345678, 0, 0, 26'h2ffff);
		chk(wr_data_o, 32'h12335678, "pc upper");
		run(IEB_OP_PC_UPPER_AL, 32'h12345678, 0, 0, 26'h2ffff);
		chk(wr_data_o, 32'h12330000, "pc aligned");
		run(IEB_OP_ADD_SIGNED, 0, 32'h7fffffff, 1, 1);
		chk({overflow_exc_o, wr_en_o}, 2'b10, "signed ovf");
		run(IEB_OP_ADD_NOTRAP, 0, 32'h7fffffff, 1, 1);
		chk(wr_data_o, 32'h80000000, "notrap sum");
		chk(overflow_exc_o, 0, "notrap flag");
		run(IEB_OP_BIT_REVERSE, 0, 32'h011280f0, 32'h011280f0, 0);
		chk(wr_data_o, 32'h8048010f, "bit reverse");
		lops = '{IEB_OP_SUB_NOTRAP, IEB_OP_OR, IEB_OP_XOR, IEB_OP_NOR,
			IEB_OP_SLT, IEB_OP_SLTU};
		lex = '{32'h7fffffff, 32'hffff8001, 32'h7fff8001, 32'h7ffffffe,
			32'h1, 32'h0};
		for (int i = 0; i < 6; i++) begin
			run(lops[i], 0, 32'h80000000, 1, 26'h8001);
			chk(wr_data_o, lex[i], "logic and compare");
		end
		run(IEB_OP_SUB_SIGNED, 0, 32'h80000000, 1, 0);
		chk({overflow_exc_o, wr_en_o}, 2'b10, "sub ovf");
	endtask

	task automatic t_muldiv;
		ieb_op_e ops [4];
		logic [31:0] ex [4];
		ops = '{IEB_OP_QUOT_S, IEB_OP_QUOT_U, IEB_OP_REM_S, IEB_OP_REM_U};
		ex = '{32'hfffffffd, 32'h7ffffffc, 32'hffffffff, 32'h1};
		dest_i = 5'h7;
		put(IEB_OP_PROD_LO_U, 0, '1, 2, 0);
		put(IEB_OP_PROD_HI_U, 0, '1, 2, 0);
		chk(wr_data_o, 32'hfffffffe, "low unsigned");
		put(IEB_OP_PROD_LO_S, 0, '1, 2, 0);
		chk(wr_data_o, 32'h1, "high unsigned reuse");
		chk(wr_dest_o, 5'h7, "high dest");
		put(IEB_OP_PROD_HI_S, 0, '1, 2, 0);
		chk(wr_data_o, 32'hfffffffe, "low signed");
		fin;
		chk(wr_data_o, 32'hffffffff, "high signed");
		for (int i = 0; i < 4; i++) begin
			run(ops[i], 0, 32'hfffffff9, 2, 0);
			chk(wr_data_o, ex[i], "divide");
		end
	endtask

	task automatic t_far;
		run(IEB_OP_FAR_CALL, 32'h100, 0, 0, 26'h3ffffff);
		chk(target_o, 32'h100, "far target");
		chk(wr_dest_o, 5'h1f, "link dest");
		chk(wr_data_o, 32'h104, "link data");
		chk({slot_delay_o, slot_forbidden_o}, 0, "no slot");
		@(posedge clk_i);
		#1;
		chk(fetch_pc, 32'h100, "fetch moved");
		chk(link_reg, 32'h104, "link stored");
		run(IEB_OP_REGOFF_CALL, 0, 32'h2000, 0, 26'hfffe);
		chk(wr_dest_o, 5'h1f, "reg call link");
		chk(target_o, 32'h1ffe, "reg jump");
	endtask

	task automatic t_compact;
		ieb_op_e ops [10];
		logic [9:0] tk;
		logic [31:0] a;
		ops = '{IEB_OP_BR_ZERO_C, IEB_OP_BR_NZERO_C, IEB_OP_BR_EQ_C,
			IEB_OP_BR_NE_C, IEB_OP_BR_GE_C, IEB_OP_BR_LT_C, IEB_OP_BR_GEU_C,
			IEB_OP_BR_LTU_C, IEB_OP_BR_OV_C, IEB_OP_BR_NOV_C};
		tk = 10'b0101101001;
		for (int i = 0; i < 10; i++) begin
			a = (i < 2) ? 32'h0 : ((i < 8) ? '1 : 32'h7fffffff);
			run(ops[i], 32'h400, a, 1, 26'h3ff0001);
			chk(redirect_o, tk[i], "compact taken");
			if (i == 0) chk(target_o, 32'hfffc0408, "zero target");
			if (i > 1 && tk[i]) chk(target_o, 32'h408, "cmp target");
			chk(slot_forbidden_o, 1, "forbidden slot");
			run(IEB_OP_NOP, 0, 0, 0, 0);
		end
	endtask

	task automatic t_slots;
		dcond_i = IEB_DCOND_EQ;
		put(IEB_OP_BR_DELAYED, 32'h800, 5, 5, 26'hfffe);
		put(IEB_OP_FAR_JUMP, 0, 0, 0, 1);
		chk(redirect_o, 1, "delayed taken");
		chk(target_o, 32'h7fc, "delayed");
		chk(slot_delay_o, 1, "delay slot");
		fin;
		chk({reserved_exc_o, redirect_o}, 2'b10, "cti in slot");
		dcond_i = IEB_DCOND_NE;
		put(IEB_OP_BR_DELAYED, 32'h800, 5, 5, 26'hfffe);
		put(IEB_OP_ADD_NOTRAP, 0, 1, 1, 1);
		chk({redirect_o, slot_delay_o}, 2'b01, "not taken");
		fin;
		chk(wr_en_o, 1, "slot executes");
		put(IEB_OP_JUMP_ABS, 32'ha0000000, 0, 0, 26'h10);
		put(IEB_OP_SLOT_BANNED, 0, 0, 0, 0);
		chk(target_o, 32'ha0000040, "abs jump");
		fin;
		chk(reserved_exc_o, 1, "banned in slot");
		put(IEB_OP_BR_NE_C, 0, 1, 1, 0);
		put(IEB_OP_FAR_CALL, 0, 0, 0, 0);
		fin;
		chk({reserved_exc_o, wr_en_o}, 2'b10, "call in forbidden");
		run(IEB_OP_NOP, 0, 0, 0, 0);
		put(IEB_OP_JUMP_REG, 0, 32'h1234, 0, 0);
		put(IEB_OP_NOP, 0, 0, 0, 0);
		chk({redirect_o, slot_delay_o}, 2'b11, "reg jump");
		chk(target_o, 32'h1234, "reg jump target");
		fin;
		for (int c = 2; c < 6; c++) begin
			dcond_i = ieb_dcond_e'(c);
			put(IEB_OP_BR_DELAYED, 32'h800, '1, 0, 26'h1);
			put(IEB_OP_NOP, 0, 0, 0, 0);
			chk(redirect_o, !c[0], "zero condition");
			chk(target_o, 32'h808, "cond target");
			fin;
		end
	endtask

	// Reset in mid-run must drop a pending delay slot
	task automatic t_reset;
		put(IEB_OP_JUMP_ABS, 0, 0, 0, 26'h4);
		@(posedge clk_i);
		#1;
		rst_i = 1'b1;
		issue_valid_i = 1'b0;
		@(posedge clk_i);
		#1;
		chk({redirect_o, slot_delay_o}, 0, "reset clears");
		rst_i = 1'b0;
		run(IEB_OP_FAR_JUMP, 32'h40, 0, 0, 0);
		chk({reserved_exc_o, redirect_o}, 2'b01, "after reset");
	endtask

	task automatic final_report;
		$display("Counts: %0d checked, %0d mismatched", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Watchdog in case the sequence stalls
	initial begin
		repeat (5000) @(posedge clk_i);
		err_count++;
		$display("unexpected at %0t: run too long", $time);
		final_report;
	end

	initial begin
		repeat (20) @(posedge clk_i);
		#1;
		rst_i = 0;
		t_alu;
		t_muldiv;
		t_far;
		t_compact;
		t_slots;
		t_reset;
		final_report;
	end
endmodule
